// ### core/hbd_pkg.sv
// Purpose: Shared constants of the host buffer descriptor setup block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Register offsets are byte addresses on the plain register port.
package hbd_pkg;

  // Register port geometry
  localparam int          REG_AW        = 8;
  localparam logic [7:0]  OFS_CTRL      = 8'h00; // Enable and return flags, write applies
  localparam logic [7:0]  OFS_SIZE      = 8'h04;
  localparam logic [7:0]  OFS_LIST_LO   = 8'h08;
  localparam logic [7:0]  OFS_LIST_HI   = 8'h0C;
  localparam logic [7:0]  OFS_COUNT     = 8'h10;
  localparam logic [7:0]  OFS_STATUS    = 8'h14;
  localparam logic [7:0]  OFS_ENT_SEL   = 8'h18;
  localparam logic [7:0]  OFS_ENT_LO    = 8'h1C;
  localparam logic [7:0]  OFS_ENT_HI    = 8'h20;
  localparam logic [7:0]  OFS_ENT_PAGES = 8'h24;
  localparam logic [7:0]  OFS_QUERY     = 8'h28;
  localparam logic [7:0]  OFS_CMPL_DW0  = 8'h2C;
  localparam logic [7:0]  OFS_BYTES_LO  = 8'h30;
  localparam logic [7:0]  OFS_BYTES_HI  = 8'h34;

  // Flag word fields
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_RET_BIT  = 1;

  // Status word fields
  localparam int          ST_BUSY       = 0;
  localparam int          ST_ENABLED    = 1;
  localparam int          ST_RETURNED   = 2;
  localparam int          ST_ERR_LIST   = 3;
  localparam int          ST_ERR_COUNT  = 4;
  localparam int          ST_ERR_ALIGN  = 5;
  localparam int          ST_ERR_ZERO   = 6;
  localparam int          ST_QUERY_BUSY = 7;
  localparam int          ST_SIZE_DIFF  = 8;
  localparam int          ST_LOADED_LSB = 16;

  // Descriptor list layout
  localparam int          ENTRY_SHIFT   = 4;   // 16 bytes per entry
  localparam int          LIST_ALIGN_W  = 4;   // Reserved low bits of list address
  localparam int          DESC_ADDR_MSB = 63;
  localparam int          DESC_PG_LSB   = 64;
  localparam int          DESC_PG_MSB   = 95;

  // Page size: 2^(12 + code) bytes
  localparam int          PAGE_CODE_W   = 4;
  localparam int          PAGE_SHIFT_W  = 6;
  localparam logic [5:0]  PAGE_SHIFT_MIN = 6'h0C;

  // Attribute structure: 4096 bytes as 1024 dwords
  localparam int          ATTR_IDX_W    = 10;
  localparam logic [9:0]  ATTR_LAST     = 10'h3FF;
  localparam logic [9:0]  ATTR_SIZE_DW  = 10'h000;
  localparam logic [9:0]  ATTR_LO_DW    = 10'h001;
  localparam logic [9:0]  ATTR_HI_DW    = 10'h002;
  localparam logic [9:0]  ATTR_CNT_DW   = 10'h003;

  // Reset values
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;

endpackage

// ### core/hbd_desc_check.sv
// Purpose: Decode one 128-bit descriptor entry and check it.
// Assumes: Page size code from controller configuration.
// Notes:   Pure combinational.
`timescale 1ns/1ns
module hbd_desc_check
  import hbd_pkg::*;
(
  // Entry and page size
  input  wire logic [127:0]            entry,
  input  wire logic [PAGE_CODE_W-1:0]  page_code,
  // Decoded fields
  output logic      [63:0]             descriptor_base_addr,
  output logic      [31:0]             descriptor_page_count,
  output logic      [63:0]             byte_len,
  output logic                         aligned,
  output logic                         nonzero
);
  logic [PAGE_SHIFT_W-1:0] shift;
  logic [63:0]             mask;

  // Split entry, reserved top word dropped
  always_comb begin
    shift                 = PAGE_SHIFT_MIN + PAGE_SHIFT_W'(page_code);
    mask                  = (64'h1 << shift) - 64'h1;
    descriptor_base_addr  = entry[DESC_ADDR_MSB:0];
    descriptor_page_count = entry[DESC_PG_MSB:DESC_PG_LSB];
    byte_len              = {32'h0, descriptor_page_count} << shift;
    aligned               = (descriptor_base_addr & mask) == 64'h0;
    nonzero               = descriptor_page_count != 32'h0;
  end
endmodule

// ### core/hbd_attr_word.sv
// Purpose: Select one dword of the attribute structure.
// Assumes: Index counts dwords from byte 0.
// Notes:   Dwords past the fourth read as zero.
`timescale 1ns/1ns
module hbd_attr_word
  import hbd_pkg::*;
(
  // Index and stored parameters
  input  wire logic [ATTR_IDX_W-1:0] index,
  input  wire logic [31:0]           size_pages,
  input  wire logic [31:0]           addr_lo,
  input  wire logic [31:0]           addr_hi,
  input  wire logic [31:0]           entries,
  // Selected dword
  output logic      [31:0]           word
);
  // Byte layout of the returned structure
  always_comb begin
    case (index)
      ATTR_SIZE_DW: word = size_pages;
      ATTR_LO_DW:   word = {addr_lo[31:LIST_ALIGN_W], 4'h0};
      ATTR_HI_DW:   word = addr_hi;
      ATTR_CNT_DW:  word = entries;
      default:      word = RST_WORD;
    endcase
  end
endmodule

// ### core/hbd_setup.sv
// Purpose: Host buffer setup: take parameters, walk descriptor list, answer query.
// Assumes: Host memory read port returns one 16-byte entry per request.
// Notes:   One read outstanding; descriptors held in a flip-flop table.
`timescale 1ns/1ns
module hbd_setup
  import hbd_pkg::*;
#(
  parameter int MAX_ENTRIES = 8
)(
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   reset,
  // Register port
  input  wire logic [REG_AW-1:0]      reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_write,
  input  wire logic                   reg_read,
  output logic      [31:0]            reg_rdata,
  // Controller configuration
  input  wire logic [PAGE_CODE_W-1:0] configured_page_size,
  // Host memory read port
  output logic                        mem_rd_req,
  output logic      [63:0]            mem_rd_addr,
  input  wire logic                   mem_rd_valid,
  input  wire logic [127:0]           mem_rd_data,
  // Query answer
  output logic      [31:0]            cmpl_dw0,
  output logic                        attr_valid,
  output logic      [ATTR_IDX_W-1:0]  attr_index,
  output logic      [31:0]            attr_data,
  input  wire logic                   attr_ready,
  output logic                        attr_done,
  // Buffer state to the controller
  output logic                        host_buffer_enable
);
  localparam int IW = $clog2(MAX_ENTRIES) + 1;

  typedef enum logic [1:0] {W_IDLE = 2'b01, W_FETCH = 2'b10} hbd_walk_t;
  typedef enum logic [1:0] {Q_IDLE = 2'b01, Q_SEND = 2'b10} hbd_query_t;

  hbd_walk_t       walk_q, walk_d;
  hbd_query_t      qry_q, qry_d;
  logic [31:0]     size_q, size_d, lo_q, lo_d, hi_q, hi_d, count_q, count_d;
  logic            en_q, en_d, ret_q, ret_d;
  logic [3:0]      err_q, err_d;
  logic            diff_q, diff_d;
  logic [IW-1:0]   n_q, n_d, loaded_q, loaded_d;
  logic [IW-1:0]   sel_q, sel_d;
  logic [31:0]     sum_q, sum_d;
  logic [63:0]     bytes_q, bytes_d;
  logic [63:0]     ent_addr_q [MAX_ENTRIES];
  logic [63:0]     ent_addr_d [MAX_ENTRIES];
  logic [31:0]     ent_pg_q   [MAX_ENTRIES];
  logic [31:0]     ent_pg_d   [MAX_ENTRIES];
  logic            req_q, req_d;
  logic [63:0]     raddr_q, raddr_d;
  logic [31:0]     rdata_q, rdata_d;
  logic [31:0]     dw0_q, dw0_d;
  logic            av_q, av_d, adone_q, adone_d;
  logic [ATTR_IDX_W-1:0] aidx_q, aidx_d, anext;
  logic [31:0]     adata_q, adata_d, aword;
  logic [63:0]     d_addr, d_len, list_base;
  logic [31:0]     d_pages;
  logic            d_ok_align, d_nonzero;
  logic            wr_ctrl, want_en;

  // Entry decoder for the word just returned
  hbd_desc_check u_check (
    .entry                 (mem_rd_data),
    .page_code             (configured_page_size),
    .descriptor_base_addr  (d_addr),
    .descriptor_page_count (d_pages),
    .byte_len              (d_len),
    .aligned               (d_ok_align),
    .nonzero               (d_nonzero)
  );

  // Attribute dword for the next index to send
  hbd_attr_word u_attr (
    .index      (anext),
    .size_pages (size_q),
    .addr_lo    (lo_q),
    .addr_hi    (hi_q),
    .entries    ({{(32-IW){1'b0}}, loaded_q}),
    .word       (aword)
  );

  // List base: high word above aligned low word
  assign list_base = {hi_q, lo_q[31:LIST_ALIGN_W], 4'h0};
  assign wr_ctrl   = reg_write && (reg_addr == OFS_CTRL);
  assign want_en   = reg_wdata[CTRL_EN_BIT];
  assign anext     = (qry_q == Q_IDLE) ? ATTR_SIZE_DW : aidx_q + ATTR_IDX_W'(1);

  // Parameter capture, enable handling and descriptor walk
  always_comb begin
    walk_d   = walk_q;
    size_d   = size_q;
    lo_d     = lo_q;
    hi_d     = hi_q;
    count_d  = count_q;
    en_d     = en_q;
    ret_d    = ret_q;
    err_d    = err_q;
    diff_d   = diff_q;
    n_d      = n_q;
    loaded_d = loaded_q;
    sel_d    = sel_q;
    sum_d    = sum_q;
    bytes_d  = bytes_q;
    req_d    = req_q;
    raddr_d  = raddr_q;
    ent_addr_d = ent_addr_q;
    ent_pg_d   = ent_pg_q;
    // Parameters are frozen while the buffer is live or being walked
    if (reg_write && !en_q && walk_q == W_IDLE) begin
      if (reg_addr == OFS_SIZE)    size_d  = reg_wdata;
      if (reg_addr == OFS_LIST_LO) lo_d    = reg_wdata;
      if (reg_addr == OFS_LIST_HI) hi_d    = reg_wdata;
      if (reg_addr == OFS_COUNT)   count_d = reg_wdata;
    end
    if (reg_write && reg_addr == OFS_ENT_SEL) sel_d = reg_wdata[IW-1:0];
    case (walk_q)
      W_IDLE: begin
        if (wr_ctrl && !want_en) begin
          en_d     = 1'b0;
          loaded_d = '0;
        end else if (wr_ctrl && !en_q) begin
          ret_d   = reg_wdata[CTRL_RET_BIT];
          err_d   = 4'h0;
          diff_d  = 1'b0;
          n_d     = '0;
          sum_d   = 32'h0;
          bytes_d = 64'h0;
          if (lo_q[LIST_ALIGN_W-1:0] != 4'h0) begin
            err_d[0] = 1'b1;
          end else if (count_q == 32'h0 || count_q > 32'(MAX_ENTRIES)) begin
            err_d[1] = 1'b1;
          end else begin
            walk_d  = W_FETCH;
            req_d   = 1'b1;
            raddr_d = list_base;
          end
        end
      end
      W_FETCH: begin
        if (wr_ctrl && !want_en) begin
          walk_d = W_IDLE;
          req_d  = 1'b0;
        end else if (mem_rd_valid) begin
          ent_addr_d[n_q[IW-2:0]] = d_addr;
          ent_pg_d[n_q[IW-2:0]]   = d_pages;
          sum_d   = sum_q + d_pages;
          bytes_d = bytes_q + d_len;
          if (!d_ok_align || !d_nonzero) begin
            err_d[2] = !d_ok_align;
            err_d[3] = !d_nonzero;
            walk_d   = W_IDLE;
            req_d    = 1'b0;
          end else if (32'(n_q) + 32'h1 >= count_q) begin
            walk_d   = W_IDLE;
            req_d    = 1'b0;
            en_d     = 1'b1;
            loaded_d = n_q + IW'(1);
            diff_d   = (sum_q + d_pages) != size_q;
          end else begin
            n_d     = n_q + IW'(1);
            raddr_d = list_base + ({{(64-IW){1'b0}}, n_q + IW'(1)} << ENTRY_SHIFT);
          end
        end
      end
      default: begin
        walk_d = W_IDLE;
        req_d  = 1'b0;
      end
    endcase
  end

  // Walk state registers
  always_ff @(posedge clock) begin
    if (reset) begin
      walk_q   <= W_IDLE;
      size_q   <= RST_WORD;
      lo_q     <= RST_WORD;
      hi_q     <= RST_WORD;
      count_q  <= RST_WORD;
      en_q     <= 1'b0;
      ret_q    <= 1'b0;
      err_q    <= 4'h0;
      diff_q   <= 1'b0;
      n_q      <= '0;
      loaded_q <= '0;
      sel_q    <= '0;
      sum_q    <= RST_WORD;
      bytes_q  <= 64'h0;
      req_q    <= 1'b0;
      raddr_q  <= 64'h0;
      for (int i = 0; i < MAX_ENTRIES; i++) begin
        ent_addr_q[i] <= 64'h0;
        ent_pg_q[i]   <= RST_WORD;
      end
    end else begin
      walk_q   <= walk_d;
      size_q   <= size_d;
      lo_q     <= lo_d;
      hi_q     <= hi_d;
      count_q  <= count_d;
      en_q     <= en_d;
      ret_q    <= ret_d;
      err_q    <= err_d;
      diff_q   <= diff_d;
      n_q      <= n_d;
      loaded_q <= loaded_d;
      sel_q    <= sel_d;
      sum_q    <= sum_d;
      bytes_q  <= bytes_d;
      req_q    <= req_d;
      raddr_q  <= raddr_d;
      ent_addr_q <= ent_addr_d;
      ent_pg_q   <= ent_pg_d;
    end
  end

  // Feature query: flags word and 1024-dword attribute stream
  always_comb begin
    qry_d   = qry_q;
    aidx_d  = aidx_q;
    adata_d = adata_q;
    av_d    = av_q;
    adone_d = 1'b0;
    dw0_d   = 32'h0;
    dw0_d[CTRL_EN_BIT]  = en_q;
    dw0_d[CTRL_RET_BIT] = ret_q;
    case (qry_q)
      Q_IDLE: begin
        if (reg_write && reg_addr == OFS_QUERY && reg_wdata[0]) begin
          qry_d   = Q_SEND;
          aidx_d  = anext;
          adata_d = aword;
          av_d    = 1'b1;
        end
      end
      Q_SEND: begin
        if (attr_ready) begin
          if (aidx_q == ATTR_LAST) begin
            qry_d   = Q_IDLE;
            av_d    = 1'b0;
            adone_d = 1'b1;
          end else begin
            aidx_d  = anext;
            adata_d = aword;
          end
        end
      end
      default: begin
        qry_d = Q_IDLE;
        av_d  = 1'b0;
      end
    endcase
  end

  // Query registers
  always_ff @(posedge clock) begin
    if (reset) begin
      qry_q   <= Q_IDLE;
      aidx_q  <= '0;
      adata_q <= RST_WORD;
      av_q    <= 1'b0;
      adone_q <= 1'b0;
      dw0_q   <= RST_WORD;
    end else begin
      qry_q   <= qry_d;
      aidx_q  <= aidx_d;
      adata_q <= adata_d;
      av_q    <= av_d;
      adone_q <= adone_d;
      dw0_q   <= dw0_d;
    end
  end

  // Register read mux, data one cycle after the strobe
  always_comb begin
    rdata_d = RST_WORD;
    if (reg_read) begin
      case (reg_addr)
        OFS_CTRL:      rdata_d = dw0_d;
        OFS_SIZE:      rdata_d = size_q;
        OFS_LIST_LO:   rdata_d = {lo_q[31:LIST_ALIGN_W], 4'h0};
        OFS_LIST_HI:   rdata_d = hi_q;
        OFS_COUNT:     rdata_d = count_q;
        OFS_STATUS: begin
          rdata_d[ST_BUSY]       = walk_q == W_FETCH;
          rdata_d[ST_ENABLED]    = en_q;
          rdata_d[ST_RETURNED]   = ret_q;
          rdata_d[ST_ERR_ALIGN:ST_ERR_LIST] = err_q[2:0];
          rdata_d[ST_ERR_ZERO]   = err_q[3];
          rdata_d[ST_QUERY_BUSY] = qry_q == Q_SEND;
          rdata_d[ST_SIZE_DIFF]  = diff_q;
          rdata_d[ST_LOADED_LSB +: IW] = loaded_q;
        end
        OFS_ENT_SEL:   rdata_d = {{(32-IW){1'b0}}, sel_q};
        OFS_ENT_LO:    rdata_d = (sel_q < loaded_q) ? ent_addr_q[sel_q[IW-2:0]][31:0] : RST_WORD;
        OFS_ENT_HI:    rdata_d = (sel_q < loaded_q) ? ent_addr_q[sel_q[IW-2:0]][63:32] : RST_WORD;
        OFS_ENT_PAGES: rdata_d = (sel_q < loaded_q) ? ent_pg_q[sel_q[IW-2:0]] : RST_WORD;
        OFS_CMPL_DW0:  rdata_d = dw0_q;
        OFS_BYTES_LO:  rdata_d = bytes_q[31:0];
        OFS_BYTES_HI:  rdata_d = bytes_q[63:32];
        default:       rdata_d = RST_WORD;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_q <= RST_WORD;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata          = rdata_q;
  assign mem_rd_req         = req_q;
  assign mem_rd_addr        = raddr_q;
  assign cmpl_dw0           = dw0_q;
  assign attr_valid         = av_q;
  assign attr_index         = aidx_q;
  assign attr_data          = adata_q;
  assign attr_done          = adone_q;
  assign host_buffer_enable = en_q;
endmodule

// ### dv/hbd_setup_sva.sv
// Purpose: Port-level assertions for the host buffer setup block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Attached to every hbd_setup by the bind at the foot.
`timescale 1ns/1ns
module hbd_setup_sva
  import hbd_pkg::*;
#(
  parameter int MAX_ENTRIES = 8
)(
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  reset,
  // Host memory read port
  input wire logic                  mem_rd_req,
  input wire logic [63:0]           mem_rd_addr,
  input wire logic                  mem_rd_valid,
  // Query answer and buffer state
  input wire logic [31:0]           cmpl_dw0,
  input wire logic                  attr_valid,
  input wire logic [ATTR_IDX_W-1:0] attr_index,
  input wire logic [31:0]           attr_data,
  input wire logic                  attr_ready,
  input wire logic                  attr_done,
  input wire logic                  host_buffer_enable
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  // One attribute dword handed over
  sequence take_s;
    attr_valid && attr_ready;
  endsequence
  // One entry returned while a read is open
  sequence entry_s;
    mem_rd_req && mem_rd_valid;
  endsequence

  list_align_a: assert property (mem_rd_req |-> mem_rd_addr[3:0] == 4'h0)
    else $error("descriptor read not on a 16-byte boundary");
  entry_step_a: assert property (entry_s ##1 mem_rd_req |-> mem_rd_addr == $past(mem_rd_addr) + 64'h10)
    else $error("next entry address is not sixteen bytes on");
  entry_hold_a: assert property (mem_rd_req && !mem_rd_valid ##1 mem_rd_req |-> $stable(mem_rd_addr))
    else $error("open read changed its address");
  walk_quiet_a: assert property (mem_rd_req |-> !host_buffer_enable)
    else $error("buffer live while the list is still walked");
  enable_late_a: assert property ($rose(host_buffer_enable) |-> $past(mem_rd_valid))
    else $error("buffer went live without a last entry");
  cmpl_rsvd_a: assert property (cmpl_dw0[31:2] == 30'h0)
    else $error("completion word has reserved bits set");
  attr_hold_a: assert property (attr_valid && !attr_ready |=> attr_valid && $stable(attr_index) && $stable(attr_data))
    else $error("offered dword changed before it was taken");
  attr_next_a: assert property (take_s ##0 attr_index != ATTR_LAST |=> attr_valid && attr_index == $past(attr_index) + 10'h001)
    else $error("attribute index did not step by one");
  attr_end_a: assert property (take_s ##0 attr_index == ATTR_LAST |=> attr_done && !attr_valid)
    else $error("structure end not signalled");
  attr_rsvd_a: assert property (attr_valid && attr_index > ATTR_CNT_DW |-> attr_data == 32'h0)
    else $error("reserved attribute dword not zero");
  attr_nibble_a: assert property (attr_valid && attr_index == ATTR_LO_DW |-> attr_data[3:0] == 4'h0)
    else $error("reported list address low nibble not zero");
endmodule

bind hbd_setup hbd_setup_sva #(.MAX_ENTRIES(MAX_ENTRIES)) hbd_setup_sva_i (
  .clock(clock), .reset(reset), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
  .mem_rd_valid(mem_rd_valid), .cmpl_dw0(cmpl_dw0), .attr_valid(attr_valid), .attr_index(attr_index),
  .attr_data(attr_data), .attr_ready(attr_ready), .attr_done(attr_done), .host_buffer_enable(host_buffer_enable)
);

// ### dv/hbd_host_mem.sv
// Purpose: Host memory holding the descriptor list.
// Assumes: Bench fills the entry table before enabling.
// Notes:   Answers after a set number of wait cycles.
`timescale 1ns/1ns
module hbd_host_mem (
  // Clock and reset
  input wire logic          clock,
  input wire logic          reset,
  // Bench control
  input wire logic [63:0]   list_base,
  input wire logic [3:0]    delay,
  // Memory read port
  input wire logic          mem_rd_req,
  input wire logic [63:0]   mem_rd_addr,
  output logic              mem_rd_valid,
  output logic [127:0]      mem_rd_data
);
  logic [127:0] ent [0:7];  // Table stays fixed while the buffer is live
  logic [3:0]   wait_q, wait_d;
  logic         valid_q, valid_d;
  logic [127:0] data_q, data_d;
  logic [63:0]  idx;

  // Entry n sits sixteen n bytes past the base; idle data toggles
  always_comb begin
    idx = (mem_rd_addr - list_base) >> 4;
    wait_d = wait_q + 4'h1;
    valid_d = 1'b0;
    data_d = ~data_q;
    if (!mem_rd_req || valid_q) begin
      wait_d = 4'h0;
    end else if (wait_q == delay) begin
      valid_d = 1'b1;
      data_d = (idx < 64'h8) ? ent[idx[2:0]] : {8{16'hDEAD}};
    end
  end

  // Register the answer
  always_ff @(posedge clock) begin
    if (reset) begin
      wait_q <= 4'h0;
      valid_q <= 1'b0;
      data_q <= 128'h0;
    end else begin
      wait_q <= wait_d;
      valid_q <= valid_d;
      data_q <= data_d;
    end
  end
  assign mem_rd_valid = valid_q;
  assign mem_rd_data = data_q;
endmodule

// ### dv/hbd_setup_tb.sv
// Purpose: Self-checking bench for the host buffer setup block.
// Assumes: 50 MHz clock, three reset cycles.
// Notes:   Register tasks speak the one-cycle strobe port.
`timescale 1ns/1ns
module hbd_setup_tb
  import hbd_pkg::*;
;
  logic clock, reset, reg_write, reg_read, mem_rd_req, mem_rd_valid;
  logic attr_valid, attr_ready, attr_done, host_buffer_enable;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata, reg_rdata, cmpl_dw0, attr_data;
  logic [3:0]   page_code, delay;
  logic [63:0]  mem_rd_addr;
  logic [127:0] mem_rd_data;
  logic [9:0]   attr_index;
  logic [31:0]  seen [0:3];
  int           n_fail, check_count, n_reads, n_done, cycles;

  hbd_setup #(.MAX_ENTRIES(8)) hbd_setup_i (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .configured_page_size(page_code), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .cmpl_dw0(cmpl_dw0),
    .attr_valid(attr_valid), .attr_index(attr_index), .attr_data(attr_data), .attr_ready(attr_ready),
    .attr_done(attr_done), .host_buffer_enable(host_buffer_enable)
  );
  hbd_host_mem hbd_host_mem_i (
    .clock(clock), .reset(reset), .list_base(64'h0000_0001_0000_1000), .delay(delay),
    .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data)
  );

  // Clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata & mask, exp);
  endtask

  // Let a walk finish under a bound
  task automatic settle();
    repeat (2) @(posedge clock);
    for (int i = 0; i < 200 && mem_rd_req === 1'b1; i++) @(posedge clock);
    #1;
  endtask

  // Count reads, collect dwords, cut a hang short
  always @(posedge clock) begin
    cycles <= cycles + 1;
    attr_ready <= ~attr_ready;
    if (mem_rd_req && mem_rd_valid) n_reads <= n_reads + 1;
    if (attr_valid && attr_ready && attr_index < 10'h004) seen[attr_index[1:0]] <= attr_data;
    if (attr_done) n_done <= n_done + 1;
    if (cycles == 20000) begin
      n_fail++;
      final_report();
    end
  end

  // Main sequence
  initial begin
    {reset, reg_write, reg_read, attr_ready} = 4'b1000;
    {reg_addr, reg_wdata, page_code, delay} = 48'h0;
    {n_fail, check_count, n_reads, n_done, cycles} = '0;
    hbd_host_mem_i.ent[0] = {32'hFFFF_FFFF, 32'h1, 64'h0000_0002_0000_0000};
    hbd_host_mem_i.ent[1] = {32'hA5A5_A5A5, 32'h2, 64'h0000_0000_0000_3000};
    hbd_host_mem_i.ent[2] = {32'h0000_0001, 32'h5, 64'h0000_0000_0000_5000};
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    rd(OFS_STATUS, 32'h0, 32'hFFFF_FFFF);
    rd(8'hFC, 32'h0, 32'hFFFF_FFFF);
    chk(cmpl_dw0, 64'h0);
    wr(OFS_SIZE, 32'hFFFF_FFFF);
    rd(OFS_SIZE, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    wr(OFS_LIST_LO, 32'h0000_100F);
    rd(OFS_LIST_LO, 32'h0000_1000, 32'hFFFF_FFFF);
    wr(OFS_LIST_HI, 32'h0000_0001);
    rd(OFS_LIST_HI, 32'h0000_0001, 32'hFFFF_FFFF);
    wr(OFS_COUNT, 32'h3);
    wr(OFS_SIZE, 32'h8);
    // Low nibble set: enable refused with list error, no read made
    wr(OFS_CTRL, 32'h1);
    rd(OFS_STATUS, 32'h8, 32'hFFFF_FFFF);
    chk(n_reads, 64'h0);
    wr(OFS_LIST_LO, 32'h0000_1000);
    $display("test parameters done");
    wr(OFS_CTRL, 32'h3);
    rd(OFS_STATUS, 32'h1, 32'h3);
    settle();
    chk(n_reads, 64'h3);
    chk(host_buffer_enable, 64'h1);
    chk(cmpl_dw0, 64'h3);
    rd(OFS_STATUS, 32'h0003_0006, 32'hFFFF_FFFF);
    wr(OFS_ENT_SEL, 32'h2);
    rd(OFS_ENT_PAGES, 32'h5, 32'hFFFF_FFFF);
    rd(OFS_ENT_LO, 32'h5000, 32'hFFFF_FFFF);
    rd(OFS_BYTES_LO, 32'h8000, 32'hFFFF_FFFF);
    rd(OFS_BYTES_HI, 32'h0, 32'hFFFF_FFFF);
    rd(OFS_CTRL, 32'h3, 32'hFFFF_FFFF);
    rd(OFS_CMPL_DW0, 32'h3, 32'hFFFF_FFFF);
    wr(OFS_ENT_SEL, 32'h0);
    rd(OFS_ENT_HI, 32'h2, 32'hFFFF_FFFF);
    wr(OFS_SIZE, 32'h9);
    rd(OFS_SIZE, 32'h8, 32'hFFFF_FFFF);
    $display("test walk done");
    wr(OFS_QUERY, 32'h1);
    rd(OFS_STATUS, 32'h80, 32'h80);
    for (int i = 0; i < 3000 && n_done == 0; i++) @(posedge clock);
    chk(n_done, 64'h1);
    chk({seen[1], seen[0]}, 64'h0000_1000_0000_0008);
    chk({seen[3], seen[2]}, 64'h0000_0003_0000_0001);
    $display("test query done");
    wr(OFS_CTRL, 32'h0);
    settle();
    chk(host_buffer_enable, 64'h0);
    rd(OFS_STATUS, 32'h0, 32'hFFFF_0002);
    @(posedge clock);
    page_code <= 4'h1;
    delay <= 4'h5;
    wr(OFS_CTRL, 32'h1);
    settle();
    chk(n_reads, 64'h5);
    chk(host_buffer_enable, 64'h0);
    rd(OFS_STATUS, 32'h20, 32'h22);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_CTRL, 32'h1);
    settle();
    chk(n_reads, 64'h5);
    rd(OFS_STATUS, 32'h10, 32'h12);
    $display("test errors done");
    final_report();
  end
endmodule
